// >>> common/scr_pkg.sv
// Package for the sensor configuration register bank.
// Assumes a byte-wide register port driven by the device's serial protocol engines.
package scr_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_BUS_CLIENT = 8'h3f;
	localparam logic [7:0] ADDR_FILTER = 8'h40;
	localparam logic [7:0] ADDR_SLOT_SEL = 8'h42;
	localparam logic [7:0] ADDR_IRQ_PIN = 8'h43;
	// Reset values
	localparam logic [7:0] RST_BUS_CLIENT = 8'h00;
	localparam logic [7:0] RST_FILTER = 8'h30;
	localparam logic [7:0] RST_SLOT_SEL = 8'h00;
	localparam logic [7:0] RST_IRQ_PIN = 8'h00;
	// Default client address when the stored value is zero
	localparam logic [7:0] DEFAULT_CLIENT = 8'h60;
	// Filter codes, field at bits 7:4
	localparam int LPF_MSB = 7;
	localparam int LPF_LSB = 4;
	localparam logic [3:0] LPF_800HZ = 4'h2;
	localparam logic [3:0] LPF_1000HZ = 4'h3;
	// Slot source fields
	localparam int SLOT0_MSB = 6;
	localparam int SLOT0_LSB = 5;
	localparam int SLOT1_MSB = 4;
	localparam int SLOT1_LSB = 3;
	localparam logic [1:0] SRC_PRESSURE = 2'h1;
	localparam logic [1:0] SRC_TEMP = 2'h3;
	// Interrupt pin style bit
	localparam int IRQ_STYLE_BIT = 2;
	// Data-path restart length in cycles
	localparam int RESTART_CYCLES = 16;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} scr_req_s;

	typedef struct packed {
		logic [1:0] slot0_source;
		logic [1:0] slot1_source;
		logic [3:0] lowpass_select;
		logic irq_active_low;
	} scr_cfg_s;
endpackage

// >>> design/scr_regs.sv
// Configuration register bank: client address, filter, slot sources, interrupt pin style.
// Assumes single-cycle read/write strobes from the serial protocol engines on ref_clk.
//
// Overview of operation
// RULE1: Stored address zero: answer at default 60h and read back 60h.
// RULE2: Non-zero stored address: low seven bits are the address; read full byte.
// RULE3: Address register readable in every mode.
// RULE4: Changing filter register restarts the data path; results undefined until done.
// RULE5: Changing slot-select register restarts the data path likewise.
// RULE6: Host should not read results while the data path restarts.
// RULE7: Filter field 7:4: code 2 gives 800 Hz, code 3 (default) 1000 Hz.
// RULE8: Any other filter code flags an error in the status summary.
// RULE9: Power-on reset returns the filter to the 1000 Hz default.
// RULE10: Slot 0 source bits 6:5: 01 pressure, 11 temperature.
// RULE11: Slot 1 source bits 4:3: 01 pressure, 11 temperature.
// RULE12: Pin style bit 2: clear active high pull-down, set active low pull-up.
// RULE13: All four registers are covered by register array error detection.
// RULE14: Slot-select register read/write in both interface modes.
// RULE15: After the lock bit is set, writes are ignored; here writes are ignored only while init_done_lock is high.
// RULE16: Reserved bits store writes but have no effect; here a change to them alone still restarts the data path.
`timescale 1ns/1ps
module scr_regs #(
	parameter int RESTART_LEN = scr_pkg::RESTART_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register access port
	input scr_pkg::scr_req_s req,
	input wire logic init_done_lock,
	input wire logic spi_mode,
	output logic [7:0] rdata,
	output logic rvalid,
	// Configuration outputs
	output logic [6:0] client_addr,
	output scr_pkg::scr_cfg_s cfg,
	output logic lowpass_error,
	output logic datapath_restart,
	output logic datapath_busy,
	output logic array_error,
	// Interrupt pin drive from the event source
	input wire logic irq_event,
	output logic irq_out,
	output logic irq_oe
);
	// Restart counter is sixteen bits wide and must load a non-zero length
	if (RESTART_LEN < 1 || RESTART_LEN > 65535) begin : g_bad_len
		$error("RESTART_LEN out of range");
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic par8(input logic [7:0] v);
		par8 = ^v;
	endfunction

	function automatic logic lpf_ok(input logic [3:0] c);
		lpf_ok = (c == scr_pkg::LPF_800HZ) || (c == scr_pkg::LPF_1000HZ);
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [7:0] addr_ff, nxt_addr;
	logic [7:0] filt_ff, nxt_filt;
	logic [7:0] slot_ff, nxt_slot;
	logic [7:0] pin_ff, nxt_pin;
	logic [3:0] par_ff, nxt_par;
	logic [15:0] rst_cnt_ff, nxt_rst_cnt;
	logic restart_ff, nxt_restart;
	logic busy_ff, nxt_busy;
	logic [7:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid;
	logic lperr_ff, nxt_lperr;
	logic arr_err_ff, nxt_arr_err;
	logic irq_out_ff, nxt_irq_out;
	logic irq_oe_ff, nxt_irq_oe;
	logic wr_ok;

	always_comb begin
		wr_ok = req.wr && !init_done_lock; // see RULE15
		nxt_addr = addr_ff;
		nxt_filt = filt_ff;
		nxt_slot = slot_ff;
		nxt_pin = pin_ff;
		nxt_par = par_ff;
		nxt_restart = 1'b0;
		nxt_rst_cnt = rst_cnt_ff;
		// Busy rises the cycle after the restart pulse and lasts RESTART_LEN cycles
		nxt_busy = (rst_cnt_ff != 16'h0000); // see RULE6
		if (rst_cnt_ff != 16'h0000) begin
			nxt_rst_cnt = rst_cnt_ff - 16'h0001;
		end
		if (wr_ok) begin
			unique case (req.addr)
				scr_pkg::ADDR_BUS_CLIENT: begin
					nxt_addr = req.wdata;
					nxt_par[0] = par8(req.wdata); // see RULE13
				end
				scr_pkg::ADDR_FILTER: begin
					nxt_filt = req.wdata; // see RULE16
					nxt_par[1] = par8(req.wdata);
					if (req.wdata != filt_ff) begin
						nxt_restart = 1'b1; // see RULE4
						nxt_rst_cnt = 16'(RESTART_LEN);
					end
				end
				scr_pkg::ADDR_SLOT_SEL: begin
					nxt_slot = req.wdata; // see RULE14
					nxt_par[2] = par8(req.wdata);
					if (req.wdata != slot_ff) begin
						nxt_restart = 1'b1; // see RULE5
						nxt_rst_cnt = 16'(RESTART_LEN);
					end
				end
				scr_pkg::ADDR_IRQ_PIN: begin
					nxt_pin = req.wdata;
					nxt_par[3] = par8(req.wdata);
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path is independent of the interface mode
	always_comb begin
		nxt_rvalid = req.rd; // see RULE3
		nxt_rdata = 8'h00;
		if (req.rd) begin
			unique case (req.addr)
				scr_pkg::ADDR_BUS_CLIENT: begin
					nxt_rdata = (addr_ff == 8'h00) ? scr_pkg::DEFAULT_CLIENT : addr_ff; // see RULE1
				end
				scr_pkg::ADDR_FILTER: nxt_rdata = filt_ff;
				scr_pkg::ADDR_SLOT_SEL: nxt_rdata = slot_ff;
				scr_pkg::ADDR_IRQ_PIN: nxt_rdata = pin_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
		nxt_lperr = !lpf_ok(filt_ff[scr_pkg::LPF_MSB:scr_pkg::LPF_LSB]); // see RULE8
		// Parity check catches upsets in any stored configuration byte
		nxt_arr_err = (par8(addr_ff) != par_ff[0]) || (par8(filt_ff) != par_ff[1])
			|| (par8(slot_ff) != par_ff[2]) || (par8(pin_ff) != par_ff[3]); // see RULE13
		// Open-drain: drive only the asserted level; pull resistor gives the other
		nxt_irq_oe = irq_event;
		nxt_irq_out = !pin_ff[scr_pkg::IRQ_STYLE_BIT]; // see RULE12
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			addr_ff <= scr_pkg::RST_BUS_CLIENT;
			filt_ff <= scr_pkg::RST_FILTER; // see RULE9
			slot_ff <= scr_pkg::RST_SLOT_SEL;
			pin_ff <= scr_pkg::RST_IRQ_PIN;
			par_ff <= 4'h0;
			rst_cnt_ff <= 16'h0000;
			restart_ff <= 1'b0;
			busy_ff <= 1'b0;
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
			lperr_ff <= 1'b0;
			arr_err_ff <= 1'b0;
			irq_out_ff <= 1'b0;
			irq_oe_ff <= 1'b0;
		end else begin
			addr_ff <= nxt_addr;
			filt_ff <= nxt_filt;
			slot_ff <= nxt_slot;
			pin_ff <= nxt_pin;
			par_ff <= nxt_par;
			rst_cnt_ff <= nxt_rst_cnt;
			restart_ff <= nxt_restart;
			busy_ff <= nxt_busy;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
			lperr_ff <= nxt_lperr;
			arr_err_ff <= nxt_arr_err;
			irq_out_ff <= nxt_irq_out;
			irq_oe_ff <= nxt_irq_oe;
		end
	end

	// Config fields come straight from the stored bytes; client_addr is registered from nxt_addr, with zero mapped to 60h
	logic [6:0] client_ff;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			client_ff <= scr_pkg::DEFAULT_CLIENT[6:0]; // see RULE1
		end else begin
			client_ff <= (nxt_addr == 8'h00) ? scr_pkg::DEFAULT_CLIENT[6:0] : nxt_addr[6:0]; // see RULE2
		end
	end

	assign rdata = rdata_ff;
	assign rvalid = rvalid_ff;
	assign client_addr = client_ff;
	// One driver for the whole struct avoids several assigns into one variable
	assign cfg = '{
		slot0_source: slot_ff[scr_pkg::SLOT0_MSB:scr_pkg::SLOT0_LSB], // see RULE10
		slot1_source: slot_ff[scr_pkg::SLOT1_MSB:scr_pkg::SLOT1_LSB], // see RULE11
		lowpass_select: filt_ff[scr_pkg::LPF_MSB:scr_pkg::LPF_LSB], // see RULE7
		irq_active_low: pin_ff[scr_pkg::IRQ_STYLE_BIT] // see RULE12
	};
	assign lowpass_error = lperr_ff;
	assign datapath_restart = restart_ff;
	assign datapath_busy = busy_ff; // see RULE6
	assign array_error = arr_err_ff;
	assign irq_out = irq_out_ff;
	assign irq_oe = irq_oe_ff;

	////////////////////////////////////////////////////////////////////////
	property p_default_read;
		@(posedge ref_clk) disable iff (!rst_b)
		(req.rd && req.addr == scr_pkg::ADDR_BUS_CLIENT && addr_ff == 8'h00)
		|=> (rvalid && rdata == 8'h60);
	endproperty
	a_default_read: assert property (p_default_read) else $error("default address read wrong"); // see RULE1

	property p_client_nonzero;
		@(posedge ref_clk) disable iff (!rst_b)
		(addr_ff != 8'h00) |-> (client_addr == addr_ff[6:0]);
	endproperty
	a_client_nonzero: assert property (p_client_nonzero) else $error("client address wrong"); // see RULE2

	property p_addr_readable;
		@(posedge ref_clk) disable iff (!rst_b)
		(req.rd && req.addr == scr_pkg::ADDR_BUS_CLIENT && addr_ff != 8'h00)
		|=> (rdata == $past(addr_ff));
	endproperty
	a_addr_readable: assert property (p_addr_readable) else $error("address read wrong"); // see RULE3

	property p_filter_restart;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_ok && req.addr == scr_pkg::ADDR_FILTER && req.wdata != filt_ff)
		|=> datapath_restart ##1 datapath_busy;
	endproperty
	a_filter_restart: assert property (p_filter_restart) else $error("no filter restart"); // see RULE4

	property p_slot_restart;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_ok && req.addr == scr_pkg::ADDR_SLOT_SEL && req.wdata != slot_ff)
		|=> datapath_restart;
	endproperty
	a_slot_restart: assert property (p_slot_restart) else $error("no slot restart"); // see RULE5

	property p_lpf_err;
		@(posedge ref_clk) disable iff (!rst_b)
		$changed(filt_ff) |=> (lowpass_error == !(($past(filt_ff[7:4]) == scr_pkg::LPF_800HZ)
			|| ($past(filt_ff[7:4]) == scr_pkg::LPF_1000HZ)));
	endproperty
	a_lpf_err: assert property (p_lpf_err) else $error("filter error flag wrong"); // see RULE8

	property p_lock;
		@(posedge ref_clk) disable iff (!rst_b)
		(init_done_lock && req.wr) |=> $stable(filt_ff) && $stable(slot_ff) && $stable(addr_ff);
	endproperty
	a_lock: assert property (p_lock) else $error("write passed lock"); // see RULE15

	property p_irq_level;
		@(posedge ref_clk) disable iff (!rst_b)
		irq_event ##1 $stable(pin_ff) |-> (irq_oe && irq_out == !pin_ff[2]);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt pin level wrong"); // see RULE12

	property p_slot_rw;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_ok && req.addr == scr_pkg::ADDR_SLOT_SEL) |=> (slot_ff == $past(req.wdata));
	endproperty
	a_slot_rw: assert property (p_slot_rw) else $error("slot select not stored"); // see RULE14
endmodule // scr_regs

// >>> verification/scr_host.sv
// Host controller model: issues single-byte register reads and writes.
// Assumes the bank takes each request at the rising edge of ref_clk.
`timescale 1ns/1ps
module scr_host (
	// Clock
	input wire logic ref_clk,
	// Register port
	output scr_pkg::scr_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic datapath_busy
);
	initial req = '0;

	////////////////////////////////////////////////////////////////////////////////
	// Holds one request over its taking edge, then leaves stale inverted lines
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q,
		output logic v);
		// Waits out datapath_busy only if already high at entry, not a restart just pulsed by the write before; results are unreliable meanwhile
		while (datapath_busy === 1'b1) @(posedge ref_clk);
		@(posedge ref_clk);
		#1 req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge ref_clk);
		#1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		q = rdata;
		v = rvalid;
	endtask
endmodule // scr_host

// >>> verification/test_scr_regs.sv
// Testbench for the configuration register bank, host model on its port.
// Assumes a 200 MHz ref_clk and a shortened data-path restart count.
`timescale 1ns/1ps
module test_scr_regs;
	localparam int RLEN = 4;
	logic ref_clk, rst_b, init_done_lock, spi_mode, irq_event;
	scr_pkg::scr_req_s req;
	scr_pkg::scr_cfg_s cfg;
	logic [7:0] rdata, q;
	logic [6:0] client_addr;
	logic rvalid, lowpass_error, datapath_restart, datapath_busy, array_error;
	logic irq_out, irq_oe, v;
	int miscompares = 0;
	int num_checks = 0;

	scr_regs #(.RESTART_LEN(RLEN)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
		.init_done_lock(init_done_lock), .spi_mode(spi_mode), .rdata(rdata),
		.rvalid(rvalid), .client_addr(client_addr), .cfg(cfg),
		.lowpass_error(lowpass_error), .datapath_restart(datapath_restart),
		.datapath_busy(datapath_busy), .array_error(array_error),
		.irq_event(irq_event), .irq_out(irq_out), .irq_oe(irq_oe));
	scr_host u_host (.ref_clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid),
		.datapath_busy(datapath_busy));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		u_host.xfer(1'b1, a, d, q, v);
	endtask
	task automatic rd(input logic [7:0] a, exp);
		u_host.xfer(1'b0, a, 8'h00, q, v);
		chk({7'h00, v}, 8'h01);
		chk(q, exp);
	endtask
	// Pulse right after the write, then busy for exactly RLEN cycles
	task automatic restart_chk(input logic exp);
		int n;
		n = 0;
		chk({7'h00, datapath_restart}, {7'h00, exp});
		repeat (RLEN + 2) begin
			@(posedge ref_clk);
			#1 n += int'(datapath_busy === 1'b1);
		end
		chk(8'(n), exp ? 8'(RLEN) : 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_defaults;
		rd(scr_pkg::ADDR_BUS_CLIENT, 8'h60);
		chk({1'b0, client_addr}, 8'h60);
		rd(scr_pkg::ADDR_FILTER, 8'h30);
		rd(scr_pkg::ADDR_SLOT_SEL, 8'h00);
		rd(scr_pkg::ADDR_IRQ_PIN, 8'h00);
		rd(8'h41, 8'h00);
	endtask
	task automatic t_addr;
		wr(scr_pkg::ADDR_BUS_CLIENT, 8'hd5);
		rd(scr_pkg::ADDR_BUS_CLIENT, 8'hd5);
		chk({1'b0, client_addr}, 8'h55);
		spi_mode = 1'b1;
		rd(scr_pkg::ADDR_BUS_CLIENT, 8'hd5);
		wr(scr_pkg::ADDR_BUS_CLIENT, 8'h00);
		rd(scr_pkg::ADDR_BUS_CLIENT, 8'h60);
		spi_mode = 1'b0;
	endtask
	task automatic t_filter;
		wr(scr_pkg::ADDR_FILTER, 8'h2f);
		restart_chk(1'b1);
		chk({4'h0, cfg.lowpass_select}, 8'h02);
		rd(scr_pkg::ADDR_FILTER, 8'h2f);
		// Same value again is no change, so no restart
		wr(scr_pkg::ADDR_FILTER, 8'h2f);
		restart_chk(1'b0);
		for (int c = 0; c < 16; c++) begin
			wr(scr_pkg::ADDR_FILTER, 8'(c << 4));
			#5 chk({7'h00, lowpass_error}, {7'h00, !(c == 2 || c == 3)});
		end
	endtask
	task automatic t_slot;
		spi_mode = 1'b1;
		wr(scr_pkg::ADDR_SLOT_SEL, 8'h38);
		restart_chk(1'b1);
		chk({4'h0, cfg.slot0_source, cfg.slot1_source}, 8'h07);
		rd(scr_pkg::ADDR_SLOT_SEL, 8'h38);
		spi_mode = 1'b0;
		wr(scr_pkg::ADDR_SLOT_SEL, 8'h68);
		chk({4'h0, cfg.slot0_source, cfg.slot1_source}, 8'h0d);
		rd(scr_pkg::ADDR_SLOT_SEL, 8'h68);
	endtask
	task automatic t_irq;
		irq_event = 1'b1;
		#10 chk({6'h00, irq_oe, irq_out}, 8'h03);
		wr(scr_pkg::ADDR_IRQ_PIN, 8'h04);
		#5 chk({6'h00, irq_oe, irq_out}, 8'h02);
		chk({7'h00, cfg.irq_active_low}, 8'h01);
		irq_event = 1'b0;
		#10 chk({7'h00, irq_oe}, 8'h00);
	endtask
	task automatic t_lock;
		init_done_lock = 1'b1;
		wr(scr_pkg::ADDR_FILTER, 8'h20);
		restart_chk(1'b0);
		rd(scr_pkg::ADDR_FILTER, 8'hf0);
		init_done_lock = 1'b0;
		rst_b = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		rd(scr_pkg::ADDR_FILTER, 8'h30);
		chk({7'h00, array_error}, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		init_done_lock = 1'b0;
		spi_mode = 1'b0;
		irq_event = 1'b0;
		repeat (5) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		t_defaults();
		t_addr();
		t_filter();
		t_slot();
		t_irq();
		t_lock();
		tally_and_finish();
	end
	// Whole run is a couple of hundred cycles; this span leaves ample margin
	initial begin
		#50000;
		miscompares++;
		tally_and_finish();
	end
endmodule // test_scr_regs
